// ==== shared/cable_diag_pkg.sv ====
// constants and types shared by the cable diagnostic result register bank
package cable_diag_pkg;

  // register port geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;

  // register offsets, one 16-bit register per address
  localparam logic [9:0] OFS_CTRL       = 10'h01E;
  localparam logic [9:0] OFS_LOC_A      = 10'h183;
  localparam logic [9:0] OFS_LOC_B      = 10'h184;
  localparam logic [9:0] OFS_AMP_A      = 10'h188;
  localparam logic [9:0] OFS_AMP_B      = 10'h189;
  localparam logic [9:0] OFS_GENERAL    = 10'h18A;
  localparam logic [9:0] OFS_IRQ_STATUS = 10'h1A0;
  localparam logic [9:0] OFS_IRQ_MASK   = 10'h1A1;

  // control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DONE_BIT  = 1;

  // amplitude and location field positions
  localparam int AMP_HI_LSB = 8;
  localparam int AMP_LO_LSB = 0;
  localparam int AMP_W      = 7;
  localparam int LOC_HI_LSB = 8;
  localparam int LOC_LO_LSB = 0;
  localparam int LOC_W      = 8;

  // general results field positions
  localparam int TX_POL_LSB   = 11;
  localparam int RX_POL_LSB   = 6;
  localparam int POL_W        = 5;
  localparam int TX_CROSS_BIT = 5;
  localparam int RX_CROSS_BIT = 4;
  localparam int TX_ABOVE_BIT = 3;
  localparam int RX_ABOVE_BIT = 2;

  // interrupt status and mask fields
  localparam int IRQ_W          = 3;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_CROSS_BIT  = 1;
  localparam int IRQ_ABOVE_BIT  = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // receive-pair peaks two to five, entry 0 is peak two
  localparam int RX_PEAKS = 4;

  // one completed measurement as delivered by the reflectometry engine
  typedef struct packed {
    logic [4:0]      txPol;
    logic [4:0]      rxPol;
    logic            txCross;
    logic            rxCross;
    logic            txAbove5;
    logic            rxAbove5;
    logic [3:0][6:0] rxAmp;
    logic [3:0][7:0] rxLoc;
  } diag_result_t;

  // measurement sequencing, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN  = 3'h2,
    ST_DONE = 3'h4
  } diag_state_t;

endpackage : cable_diag_pkg

// ==== rtl/diag_result_hold.sv ====
// holding register for one completed set of cable diagnostic results
`timescale 1ns/10ps
module diag_result_hold (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // capture request and fresh results
  input  wire logic                        captureEn,
  input  wire cable_diag_pkg::diag_result_t resultIn,
  // held results
  output cable_diag_pkg::diag_result_t     held
);

  cable_diag_pkg::diag_result_t next_held;
  logic [6:0]                   nextAmp [cable_diag_pkg::RX_PEAKS];
  logic [7:0]                   nextLoc [cable_diag_pkg::RX_PEAKS];

  // amplitude and location per receive peak; one entry per peak
  genvar gi;
  generate
    for (gi = 0; gi < cable_diag_pkg::RX_PEAKS; gi++) begin : g_peak
      always_comb begin
        nextAmp[gi] = captureEn ? resultIn.rxAmp[gi] : held.rxAmp[gi];
        nextLoc[gi] = captureEn ? resultIn.rxLoc[gi] : held.rxLoc[gi];
      end
    end
  endgenerate

  // flags and polarities load only on a completed measurement; peaks come from the loop
  always_comb begin
    next_held = held;
    if (captureEn) begin
      next_held.txPol    = resultIn.txPol;
      next_held.rxPol    = resultIn.rxPol;
      next_held.txCross  = resultIn.txCross;
      next_held.rxCross  = resultIn.rxCross;
      next_held.txAbove5 = resultIn.txAbove5;
      next_held.rxAbove5 = resultIn.rxAbove5;
    end
    for (int k = 0; k < cable_diag_pkg::RX_PEAKS; k++) begin
      next_held.rxAmp[k] = nextAmp[k];
      next_held.rxLoc[k] = nextLoc[k];
    end
  end

  // one register for the whole set, so every field has a single driver
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= '0;
    end else begin
      held <= next_held;
    end
  end

endmodule : diag_result_hold

// ==== rtl/cable_diag_results_regs.sv ====
// cable diagnostic result register bank with control, done flag and interrupt
//
// Notes on behaviour
// - results count as valid only once the done flag in control bit 1 reads 1.
// - reserved bits 15 and 7 of amplitudes and 1:0 of general read zero.
// - first amplitude register: receive peak three in 14:8, peak two in 6:0.
// - second amplitude register: receive peak five in 14:8, peak four in 6:0.
// - general bits 15 down to 11 give transmit peak polarities five to one.
// - general bits 10 down to 6 give receive peak polarities five to one.
// - bit 5 flags transmit cross reflection, bit 4 receive; both mean shorted pairs.
// - bit 3 flags over five transmit reflections, bit 2 over five receive.
// - each location byte holds one peak as an 8-bit distance code.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
module cable_diag_results_regs (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  // register port
  input  wire logic [9:0]                   regAddr,
  input  wire logic [15:0]                  regWrData,
  input  wire logic                         regWr,
  input  wire logic                         regRd,
  output logic [15:0]                       regRdData,
  // reflectometry engine
  input  wire logic                         engineDone,
  input  wire cable_diag_pkg::diag_result_t engineResult,
  output logic                              diagStart,
  // interrupt
  output logic                              irq
);

  cable_diag_pkg::diag_state_t  state;
  cable_diag_pkg::diag_state_t  next_state;
  cable_diag_pkg::diag_result_t held;
  logic [2:0]                   irqStatus;
  logic [2:0]                   next_irqStatus;
  logic [2:0]                   irqMask;
  logic [2:0]                   next_irqMask;
  logic                         next_irq;
  logic                         next_diagStart;
  logic [15:0]                  next_regRdData;
  logic                         startReq;
  logic                         captureEn;
  logic                         doneFlag;
  logic [2:0]                   irqEvents;

  // decoded requests; a start while running is dropped so results never mix
  always_comb begin
    startReq  = regWr && (regAddr == cable_diag_pkg::OFS_CTRL)
                && regWrData[cable_diag_pkg::CTRL_START_BIT]
                && (state != cable_diag_pkg::ST_RUN);
    captureEn = engineDone && (state == cable_diag_pkg::ST_RUN);
    doneFlag  = (state == cable_diag_pkg::ST_DONE);
  end

  // measurement sequencing; done is entered in the same cycle results load
  always_comb begin
    case (state)
      cable_diag_pkg::ST_IDLE: begin
        next_state = startReq ? cable_diag_pkg::ST_RUN : cable_diag_pkg::ST_IDLE;
      end
      cable_diag_pkg::ST_RUN: begin
        next_state = captureEn ? cable_diag_pkg::ST_DONE : cable_diag_pkg::ST_RUN;
      end
      cable_diag_pkg::ST_DONE: begin
        next_state = startReq ? cable_diag_pkg::ST_RUN : cable_diag_pkg::ST_DONE;
      end
      default: begin
        next_state = cable_diag_pkg::ST_IDLE;
      end
    endcase
    next_diagStart = startReq;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= cable_diag_pkg::ST_IDLE;
      diagStart <= 1'b0;
    end else begin
      state     <= next_state;
      diagStart <= next_diagStart;
    end
  end

  // results load only on a completed measurement, bus writes never reach them
  diag_result_hold u_hold (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .captureEn (captureEn),
    .resultIn  (engineResult),
    .held      (held)
  );

  // interrupt events; the set wins over a clearing read in the same cycle
  always_comb begin
    irqEvents = 3'h0;
    irqEvents[cable_diag_pkg::IRQ_DONE_BIT]  = captureEn;
    irqEvents[cable_diag_pkg::IRQ_CROSS_BIT] = captureEn
      && (engineResult.txCross || engineResult.rxCross);
    irqEvents[cable_diag_pkg::IRQ_ABOVE_BIT] = captureEn
      && (engineResult.txAbove5 || engineResult.rxAbove5);
    next_irqStatus = irqStatus;
    if (regRd && (regAddr == cable_diag_pkg::OFS_IRQ_STATUS)) begin
      next_irqStatus = 3'h0;
    end
    next_irqStatus = next_irqStatus | irqEvents;
    next_irqMask   = irqMask;
    if (regWr && (regAddr == cable_diag_pkg::OFS_IRQ_MASK)) begin
      next_irqMask = regWrData[2:0];
    end
    next_irq = |(next_irqStatus & next_irqMask);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus <= 3'h0;
      irqMask   <= cable_diag_pkg::IRQ_MASK_RESET;
      irq       <= 1'b0;
    end else begin
      irqStatus <= next_irqStatus;
      irqMask   <= next_irqMask;
      irq       <= next_irq;
    end
  end

  // read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    next_regRdData = 16'h0000;
    if (regRd) begin
      case (regAddr)
        cable_diag_pkg::OFS_CTRL: begin
          next_regRdData[cable_diag_pkg::CTRL_DONE_BIT] = doneFlag;
        end
        cable_diag_pkg::OFS_LOC_A: begin
          next_regRdData[15:8] = held.rxLoc[1];
          next_regRdData[7:0]  = held.rxLoc[0];
        end
        cable_diag_pkg::OFS_LOC_B: begin
          next_regRdData[15:8] = held.rxLoc[3];
          next_regRdData[7:0]  = held.rxLoc[2];
        end
        cable_diag_pkg::OFS_AMP_A: begin
          next_regRdData[14:8] = held.rxAmp[1];
          next_regRdData[6:0]  = held.rxAmp[0];
        end
        cable_diag_pkg::OFS_AMP_B: begin
          next_regRdData[14:8] = held.rxAmp[3];
          next_regRdData[6:0]  = held.rxAmp[2];
        end
        cable_diag_pkg::OFS_GENERAL: begin
          next_regRdData[15:11] = held.txPol;
          next_regRdData[10:6]  = held.rxPol;
          next_regRdData[cable_diag_pkg::TX_CROSS_BIT] = held.txCross;
          next_regRdData[cable_diag_pkg::RX_CROSS_BIT] = held.rxCross;
          next_regRdData[cable_diag_pkg::TX_ABOVE_BIT] = held.txAbove5;
          next_regRdData[cable_diag_pkg::RX_ABOVE_BIT] = held.rxAbove5;
        end
        cable_diag_pkg::OFS_IRQ_STATUS: begin
          next_regRdData[2:0] = irqStatus;
        end
        cable_diag_pkg::OFS_IRQ_MASK: begin
          next_regRdData[2:0] = irqMask;
        end
        default: begin
          next_regRdData = 16'h0000;
        end
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= next_regRdData;
    end
  end

  // checks on the register bank
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_read(logic [9:0] a);
    regRd && (regAddr == a);
  endsequence

  sequence s_finish;
    (state == cable_diag_pkg::ST_RUN) && engineDone;
  endsequence

  a_done_after_capture: assert property (
    $rose(doneFlag) |-> $past(captureEn)
  ) else $error("done flag rose without a result capture");

  a_done_flag_read: assert property (
    s_finish ##1 s_read(cable_diag_pkg::OFS_CTRL) |=> regRdData[1]
  ) else $error("done flag not seen after completion");

  a_rsvd_amp_zero: assert property (
    s_read(cable_diag_pkg::OFS_AMP_A) or s_read(cable_diag_pkg::OFS_AMP_B)
    |=> (regRdData[15] == 1'b0) && (regRdData[7] == 1'b0)
  ) else $error("reserved amplitude bit read as one");

  a_rsvd_gen_zero: assert property (
    s_read(cable_diag_pkg::OFS_GENERAL) |=> regRdData[1:0] == 2'h0
  ) else $error("reserved general bits read as nonzero");

  a_amp_a_map: assert property (
    s_read(cable_diag_pkg::OFS_AMP_A)
    |=> (regRdData[14:8] == $past(held.rxAmp[1])) && (regRdData[6:0] == $past(held.rxAmp[0]))
  ) else $error("first amplitude register mismatch");

  a_amp_b_map: assert property (
    s_read(cable_diag_pkg::OFS_AMP_B)
    |=> (regRdData[14:8] == $past(held.rxAmp[3])) && (regRdData[6:0] == $past(held.rxAmp[2]))
  ) else $error("second amplitude register mismatch");

  a_tx_pol_map: assert property (
    s_finish ##1 s_read(cable_diag_pkg::OFS_GENERAL)
    |=> regRdData[15:11] == $past(engineResult.txPol, 2)
  ) else $error("transmit polarity not reported");

  a_rx_pol_map: assert property (
    s_read(cable_diag_pkg::OFS_GENERAL) |=> regRdData[10:6] == $past(held.rxPol)
  ) else $error("receive polarity mismatch");

  a_cross_flags: assert property (
    s_read(cable_diag_pkg::OFS_GENERAL)
    |=> regRdData[5:4] == $past({held.txCross, held.rxCross})
  ) else $error("cross reflection flags mismatch");

  a_above_flags: assert property (
    s_read(cable_diag_pkg::OFS_GENERAL)
    |=> regRdData[3:2] == $past({held.txAbove5, held.rxAbove5})
  ) else $error("above five flags mismatch");

  a_loc_map: assert property (
    s_read(cable_diag_pkg::OFS_LOC_B)
    |=> regRdData == $past({held.rxLoc[3], held.rxLoc[2]})
  ) else $error("location register mismatch");

  a_hold_stable: assert property (
    !captureEn |=> $stable(held)
  ) else $error("results changed without a completion");

  a_irq_level: assert property (
    irq == ((irqStatus & irqMask) != 3'h0)
  ) else $error("interrupt low with unmasked status");

endmodule : cable_diag_results_regs

// ==== verif/tb_top.sv ====
// self-checking testbench for the cable diagnostic result register bank
`timescale 1ns/10ps
module tb_top;
  logic                         ref_clk;
  logic                         rst_n;
  logic [9:0]                   regAddr;
  logic [15:0]                  regWrData;
  logic                         regWr;
  logic                         regRd;
  logic [15:0]                  regRdData;
  logic                         engineDone;
  cable_diag_pkg::diag_result_t engineResult;
  logic                         diagStart;
  logic                         irq;
  int                           miscompares;
  int                           numChecks;
  int                           mask;
  cable_diag_pkg::diag_result_t res;
  cable_diag_pkg::diag_result_t expQ[$];
  logic [9:0]                   resetAddrs[8];

  cable_diag_results_regs i_dut (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .regAddr      (regAddr),
    .regWrData    (regWrData),
    .regWr        (regWr),
    .regRd        (regRd),
    .regRdData    (regRdData),
    .engineDone   (engineDone),
    .engineResult (engineResult),
    .diagStart    (diagStart),
    .irq          (irq)
  );

  // free-running core clock, 8 ns period
  always #4 ref_clk = ~ref_clk;

  task summarize;
    if (miscompares == 0 && numChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task check(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one-cycle write strobe; the slave never stalls
  task wr(input logic [9:0] addr, input logic [15:0] data);
    @(posedge ref_clk);
    regWr     <= 1'b1;
    regAddr   <= addr;
    regWrData <= data;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task rd(input logic [9:0] addr, input logic [15:0] exp);
    @(posedge ref_clk);
    regRd   <= 1'b1;
    regAddr <= addr;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 check(regRdData, exp);
  endtask : rd

  task engine(input cable_diag_pkg::diag_result_t r);
    @(posedge ref_clk);
    engineDone   <= 1'b1;
    engineResult <= r;
    @(posedge ref_clk);
    engineDone   <= 1'b0;
    engineResult <= ~r;
  endtask : engine

  // completion followed at once by a read, so the read lands in the first done cycle
  task engineRd(input cable_diag_pkg::diag_result_t r, input logic [9:0] addr, input logic [15:0] exp);
    @(posedge ref_clk);
    engineDone   <= 1'b1;
    engineResult <= r;
    @(posedge ref_clk);
    engineDone   <= 1'b0;
    engineResult <= ~r;
    regRd        <= 1'b1;
    regAddr      <= addr;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 check(regRdData, exp);
  endtask : engineRd

  // expected general results word built from the raw measurement
  function automatic logic [15:0] genWord(input cable_diag_pkg::diag_result_t r);
    return {r.txPol, r.rxPol, r.txCross, r.rxCross, r.txAbove5, r.rxAbove5, 2'b00};
  endfunction : genWord

  function automatic cable_diag_pkg::diag_result_t randResult();
    cable_diag_pkg::diag_result_t r;
    r.txPol    = 5'($urandom);
    r.rxPol    = 5'($urandom);
    r.txCross  = 1'($urandom);
    r.rxCross  = 1'($urandom);
    r.txAbove5 = 1'($urandom);
    r.rxAbove5 = 1'($urandom);
    for (int k = 0; k < 4; k++) begin
      r.rxAmp[k] = 7'($urandom);
      r.rxLoc[k] = 8'($urandom);
    end
    return r;
  endfunction : randResult

  // reference view of every result register, built from the raw measurement
  task checkResults(input cable_diag_pkg::diag_result_t r);
    rd(cable_diag_pkg::OFS_AMP_A, {1'b0, r.rxAmp[1], 1'b0, r.rxAmp[0]});
    rd(cable_diag_pkg::OFS_AMP_B, {1'b0, r.rxAmp[3], 1'b0, r.rxAmp[2]});
    rd(cable_diag_pkg::OFS_GENERAL, genWord(r));
    rd(cable_diag_pkg::OFS_LOC_A, {r.rxLoc[1], r.rxLoc[0]});
    rd(cable_diag_pkg::OFS_LOC_B, {r.rxLoc[3], r.rxLoc[2]});
  endtask : checkResults

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    summarize();
  end

  initial begin
    resetAddrs = '{10'h188, 10'h189, 10'h18A, 10'h183, 10'h184, 10'h01E, 10'h1A0, 10'h1A1};
    ref_clk      = 1'b0;
    rst_n        = 1'b0;
    regAddr      = 10'h000;
    regWrData    = 16'h0000;
    regWr        = 1'b0;
    regRd        = 1'b0;
    engineDone   = 1'b0;
    engineResult = '0;
    miscompares  = 0;
    numChecks    = 0;
    void'($urandom(32'h124BCF19));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    // every register reads zero out of reset, plus an unmapped hole
    foreach (resetAddrs[i]) rd(resetAddrs[i], 16'h0000);
    rd(10'h3FF, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    // a completion while idle must not load anything
    engine(randResult());
    expQ.push_back('0);
    checkResults(expQ[$]);
    rd(cable_diag_pkg::OFS_CTRL, 16'h0000);
    wr(cable_diag_pkg::OFS_IRQ_MASK, 16'hFFFF);
    rd(cable_diag_pkg::OFS_IRQ_MASK, 16'h0007);
    mask = 7;
    for (int i = 0; i < 6; i++) begin
      res = randResult();
      if (i == 3) begin
        wr(cable_diag_pkg::OFS_IRQ_MASK, 16'h0002);
        mask = 2;
      end
      wr(cable_diag_pkg::OFS_CTRL, 16'h0001);
      #1 check({15'h0000, diagStart}, 16'h0001);
      rd(cable_diag_pkg::OFS_CTRL, 16'h0000);
      // a second start while running is dropped
      wr(cable_diag_pkg::OFS_CTRL, 16'h0001);
      #1 check({15'h0000, diagStart}, 16'h0000);
      if (i % 2 == 0) begin
        engineRd(res, cable_diag_pkg::OFS_CTRL, 16'h0002);
      end else begin
        engineRd(res, cable_diag_pkg::OFS_GENERAL, genWord(res));
      end
      expQ.push_back(res);
      #1 check({15'h0000, irq}, {15'h0000, |(mask & {res.txAbove5 | res.rxAbove5, res.txCross | res.rxCross, 1'b1})});
      rd(cable_diag_pkg::OFS_CTRL, 16'h0002);
      checkResults(expQ[$]);
      // writes to result registers change nothing
      foreach (resetAddrs[j]) if (j < 5) wr(resetAddrs[j], 16'($urandom));
      engine(randResult());
      checkResults(expQ[$]);
      rd(cable_diag_pkg::OFS_IRQ_STATUS, {13'h0000, res.txAbove5 | res.rxAbove5, res.txCross | res.rxCross, 1'b1});
      rd(cable_diag_pkg::OFS_IRQ_STATUS, 16'h0000);
      check({15'h0000, irq}, 16'h0000);
    end
    // reset in the done state clears the held results
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    expQ.push_back('0);
    checkResults(expQ[$]);
    rd(cable_diag_pkg::OFS_CTRL, 16'h0000);
    rd(cable_diag_pkg::OFS_IRQ_MASK, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    summarize();
  end
endmodule : tb_top
